// file: core/ctrd_pkg.sv
// Constants for the core timer run, direction and toggle latch block.
// Assumes one 40 MHz clock and an AHB-Lite register bus with 32-bit data.
package ctrd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_AUX_CFG = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// Control register fields
	localparam int BIT_RDIR = 15;
	localparam int BIT_OTL = 10;
	localparam int BIT_OE = 9;
	localparam int BIT_UDE = 8;
	localparam int BIT_UD = 7;
	localparam int BIT_RUN = 6;
	localparam int MODE_LSB = 3;
	localparam int PARAM_LSB = 0;
	// Writable bits of control (reserved bits and rdir are masked off, not written)
	localparam logic [15:0] CTRL_WMASK = 16'h07FF;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// Aux config bits
	localparam int BIT_A_RC = 0;
	localparam int BIT_B_RC = 1;
	// Interrupt status bits
	localparam int IRQ_OVF = 0;
	localparam int IRQ_UNF = 1;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	// Mode encodings
	typedef enum logic [2:0] {
		MODE_TIMER = 3'h0,
		MODE_COUNTER = 3'h1,
		MODE_GATED_LO = 3'h2,
		MODE_GATED_HI = 3'h3,
		MODE_RSVD_4 = 3'h4,
		MODE_RSVD_5 = 3'h5,
		MODE_INC_ROT = 3'h6,
		MODE_INC_EDGE = 3'h7
	} ctrd_mode_t;
endpackage : ctrd_pkg

// file: core/ctrd_core.sv
// Core timer control: run, direction, mode/param fields, toggle latch, AHB-Lite slave.
// Assumes synchronous pins and a single AHB-Lite master; hready equals our hreadyout.
// Functional notes
// - Output enable drives pin with latch state
// - Output enable off holds pin high
// - Direction enable connects external direction input
// - Software direction bit: zero up, one down
// - Run bit stops or runs, all modes
// - Mode field bits five to three encoding
// - Gated mode counts when run and gate active
// - Input parameter field is mode dependent
// - Run bit also runs aux timers when enabled
// - Direction is pin XOR software when enabled
// - Direction changes accepted anytime
// - Overflow toggles latch, shadow follows one clock
// - Latch/shadow mismatch is an aux trigger edge
// - Software latch write sets both, no edge
// - Triggers usable as aux count or reload
// - Bit ten holds the toggle latch
// - Bit fifteen is read-only direction flag
module ctrd_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic count_tick,
	input wire logic gate_input,
	input wire logic count_input,
	input wire logic ext_dir_input,
	output logic toggle_output_pin,
	output logic toggle_latch_out,
	output logic shadow_latch_out,
	output logic aux_trigger,
	output logic aux_a_run,
	output logic aux_b_run,
	output logic irq
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] count;
		logic [1:0] aux_cfg;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic shadow;
		logic cnt_in_prev;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ovf_pulse;
		logic unf_pulse;
		logic pin;
	} ctrd_state_t;

	ctrd_state_t st_ff;
	ctrd_state_t nxt_st;

	logic dir_down;
	logic gate_ok;
	logic cnt_edge;
	logic advance;
	logic [2:0] mode;
	logic [2:0] param;
	logic addr_phase;
	logic [15:0] wdata16;
	logic ctrl_wr;

	assign mode = st_ff.ctrl[ctrd_pkg::MODE_LSB +: 3];
	assign param = st_ff.ctrl[ctrd_pkg::PARAM_LSB +: 3];

	// Direction: software bit, optionally reversed by the pin
	always_comb begin
		if (st_ff.ctrl[ctrd_pkg::BIT_UDE]) begin
			dir_down = ext_dir_input ^ st_ff.ctrl[ctrd_pkg::BIT_UD];
		end else begin
			dir_down = st_ff.ctrl[ctrd_pkg::BIT_UD];
		end
	end

	// Count enable per mode, qualified by run bit
	always_comb begin
		gate_ok = 1'b0;
		cnt_edge = 1'b0;
		unique case (ctrd_pkg::ctrd_mode_t'(mode))
			ctrd_pkg::MODE_TIMER: gate_ok = count_tick;
			ctrd_pkg::MODE_GATED_LO: gate_ok = count_tick & ~gate_input;
			ctrd_pkg::MODE_GATED_HI: gate_ok = count_tick & gate_input;
			ctrd_pkg::MODE_COUNTER: begin
				// Edge select from input parameter field
				unique case (param)
					3'h1: cnt_edge = count_input & ~st_ff.cnt_in_prev;
					3'h2: cnt_edge = ~count_input & st_ff.cnt_in_prev;
					3'h3: cnt_edge = count_input ^ st_ff.cnt_in_prev;
					default: cnt_edge = 1'b0;
				endcase
				gate_ok = cnt_edge;
			end
			ctrd_pkg::MODE_INC_ROT, ctrd_pkg::MODE_INC_EDGE: begin
				gate_ok = (param != 3'h0) && (param[2] == 1'b0) && (count_input ^ st_ff.cnt_in_prev);
			end
			default: gate_ok = 1'b0; // Reserved modes never count
		endcase
		advance = st_ff.ctrl[ctrd_pkg::BIT_RUN] & gate_ok;
	end

	assign addr_phase = hsel & hready & htrans[1];
	assign wdata16 = hwdata[15:0];
	// Control write in its data phase; it reloads latch and shadow together
	assign ctrl_wr = st_ff.wr_pend && (st_ff.wr_addr == ctrd_pkg::OFS_CONTROL);

	// Write data arrives one cycle after its address, so the address waits in wr_addr
	// Next state: counter, latches, registers, bus
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt_in_prev = count_input;
		nxt_st.ovf_pulse = 1'b0;
		nxt_st.unf_pulse = 1'b0;
		nxt_st.shadow = st_ff.ctrl[ctrd_pkg::BIT_OTL];
		nxt_st.ctrl[ctrd_pkg::BIT_RDIR] = dir_down;
		if (advance) begin
			if (dir_down) begin
				nxt_st.count = st_ff.count - 16'h0001;
				if (st_ff.count == ctrd_pkg::CNT_ZERO) begin
					nxt_st.unf_pulse = 1'b1;
				end
			end else begin
				nxt_st.count = st_ff.count + 16'h0001;
				if (st_ff.count == ctrd_pkg::CNT_MAX) begin
					nxt_st.ovf_pulse = 1'b1;
				end
			end
			if (nxt_st.ovf_pulse || nxt_st.unf_pulse) begin
				nxt_st.ctrl[ctrd_pkg::BIT_OTL] = ~st_ff.ctrl[ctrd_pkg::BIT_OTL];
			end
		end
		// A wrap in the same cycle as a clear must not be lost
		// Sticky interrupt flags, set beats clear
		if (st_ff.wr_pend && st_ff.wr_addr == ctrd_pkg::OFS_IRQ_STATUS) begin
			nxt_st.irq_status = st_ff.irq_status & ~hwdata[1:0];
		end
		if (nxt_st.ovf_pulse) begin
			nxt_st.irq_status[ctrd_pkg::IRQ_OVF] = 1'b1;
		end
		if (nxt_st.unf_pulse) begin
			nxt_st.irq_status[ctrd_pkg::IRQ_UNF] = 1'b1;
		end
		// Data phase of a write
		if (st_ff.wr_pend) begin
			unique case (st_ff.wr_addr)
				ctrd_pkg::OFS_CONTROL: begin
					nxt_st.ctrl = (wdata16 & ctrd_pkg::CTRL_WMASK) | {dir_down, 15'h0000};
					nxt_st.shadow = wdata16[ctrd_pkg::BIT_OTL];
				end
				ctrd_pkg::OFS_COUNT: nxt_st.count = wdata16; // CPU write wins over counting
				ctrd_pkg::OFS_AUX_CFG: nxt_st.aux_cfg = hwdata[1:0];
				ctrd_pkg::OFS_IRQ_MASK: nxt_st.irq_mask = hwdata[1:0];
				default: ;
			endcase
		end
		nxt_st.wr_pend = addr_phase & hwrite;
		nxt_st.wr_addr = {haddr[7:2], 2'b00};
		// Taken at the address edge so hrdata stands through the whole data phase
		// Read data captured in the address phase
		if (addr_phase && !hwrite) begin
			unique case ({haddr[7:2], 2'b00})
				ctrd_pkg::OFS_CONTROL: nxt_st.rdata = {16'h0000, st_ff.ctrl};
				ctrd_pkg::OFS_COUNT: nxt_st.rdata = {16'h0000, st_ff.count};
				ctrd_pkg::OFS_AUX_CFG: nxt_st.rdata = {30'h0, st_ff.aux_cfg};
				ctrd_pkg::OFS_IRQ_STATUS: nxt_st.rdata = {30'h0, st_ff.irq_status};
				ctrd_pkg::OFS_IRQ_MASK: nxt_st.rdata = {30'h0, st_ff.irq_mask};
				default: nxt_st.rdata = 32'h00000000;
			endcase
		end
		// Pin: latch state when enabled, else high
		nxt_st.pin = nxt_st.ctrl[ctrd_pkg::BIT_OE] ? nxt_st.ctrl[ctrd_pkg::BIT_OTL] : 1'b1;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.pin <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hrdata = st_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign toggle_output_pin = st_ff.pin;
	// Both latch levels go to the aux timers; a mismatch is their edge
	assign toggle_latch_out = st_ff.ctrl[ctrd_pkg::BIT_OTL];
	assign shadow_latch_out = st_ff.shadow;
	assign aux_trigger = st_ff.ctrl[ctrd_pkg::BIT_OTL] ^ st_ff.shadow;
	assign aux_a_run = st_ff.aux_cfg[ctrd_pkg::BIT_A_RC] & st_ff.ctrl[ctrd_pkg::BIT_RUN];
	assign aux_b_run = st_ff.aux_cfg[ctrd_pkg::BIT_B_RC] & st_ff.ctrl[ctrd_pkg::BIT_RUN];
	assign irq = |(st_ff.irq_status & st_ff.irq_mask);

	// Assertions
	sequence s_wrap;
		st_ff.ovf_pulse || st_ff.unf_pulse;
	endsequence
	property p_toggle;
		@(posedge clk) disable iff (sys_rst) advance && (nxt_st.ovf_pulse || nxt_st.unf_pulse) && !st_ff.wr_pend
			|=> (toggle_latch_out != $past(toggle_latch_out));
	endproperty
	a_toggle: assert property (p_toggle) else $error("latch did not toggle on wrap");
	property p_shadow;
		@(posedge clk) disable iff (sys_rst) !$past(st_ff.wr_pend) ##0 s_wrap |-> aux_trigger ##1 !aux_trigger;
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow mismatch not one cycle");
	property p_swwrite;
		@(posedge clk) disable iff (sys_rst) st_ff.wr_pend && st_ff.wr_addr == ctrd_pkg::OFS_CONTROL |=> !aux_trigger;
	endproperty
	a_swwrite: assert property (p_swwrite) else $error("software write caused edge");
	property p_pin_en;
		@(posedge clk) disable iff (sys_rst) st_ff.ctrl[ctrd_pkg::BIT_OE] |-> toggle_output_pin == toggle_latch_out;
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin not latch");
	property p_pin_dis;
		@(posedge clk) disable iff (sys_rst) !st_ff.ctrl[ctrd_pkg::BIT_OE] |-> toggle_output_pin;
	endproperty
	a_pin_dis: assert property (p_pin_dis) else $error("pin not high");
	property p_stop;
		@(posedge clk) disable iff (sys_rst) !st_ff.ctrl[ctrd_pkg::BIT_RUN] && !st_ff.wr_pend |=> $stable(st_ff.count);
	endproperty
	a_stop: assert property (p_stop) else $error("count moved while stopped");
	property p_dir;
		@(posedge clk) disable iff (sys_rst) ##1 st_ff.ctrl[ctrd_pkg::BIT_RDIR] ==
			$past(st_ff.ctrl[ctrd_pkg::BIT_UD] ^ (st_ff.ctrl[ctrd_pkg::BIT_UDE] & ext_dir_input));
	endproperty
	a_dir: assert property (p_dir) else $error("direction flag wrong");
	property p_gate;
		@(posedge clk) disable iff (sys_rst) mode == 3'h2 && gate_input |-> !advance;
	endproperty
	a_gate: assert property (p_gate) else $error("gated low counted");
	property p_aux;
		@(posedge clk) disable iff (sys_rst) !st_ff.ctrl[ctrd_pkg::BIT_RUN] |-> !aux_a_run && !aux_b_run;
	endproperty
	a_aux: assert property (p_aux) else $error("aux runs while core stopped");

	// Counter steps outside any register write
	sequence s_up_step;
		advance && !dir_down && !st_ff.wr_pend;
	endsequence
	sequence s_down_step;
		advance && dir_down && !st_ff.wr_pend;
	endsequence
	// Data phase of a control register write
	sequence s_ctrl_write;
		ctrl_wr;
	endsequence

	// Up step adds one and wraps from all ones to zero
	property p_count_up;
		@(posedge clk) disable iff (sys_rst)
			s_up_step |=> st_ff.count == $past(st_ff.count) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("up step wrong");
	// Down step takes one and wraps from zero to all ones
	property p_count_down;
		@(posedge clk) disable iff (sys_rst)
			s_down_step |=> st_ff.count == $past(st_ff.count) - 16'h0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("down step wrong");
	// Low gate level holds the count in active-high gated mode
	property p_gate_hi;
		@(posedge clk) disable iff (sys_rst)
			mode == ctrd_pkg::MODE_GATED_HI && !gate_input |-> !advance;
	endproperty
	a_gate_hi: assert property (p_gate_hi) else $error("gated high counted");
	// Open gate, run bit and tick give a step in active-low gated mode
	property p_gate_lo_run;
		@(posedge clk) disable iff (sys_rst)
			mode == ctrd_pkg::MODE_GATED_LO && !gate_input && count_tick && st_ff.ctrl[ctrd_pkg::BIT_RUN] |-> advance;
	endproperty
	a_gate_lo_run: assert property (p_gate_lo_run) else $error("gated low did not count");
	// Cleared run bit means no step in any mode
	property p_run_need;
		@(posedge clk) disable iff (sys_rst)
			!st_ff.ctrl[ctrd_pkg::BIT_RUN] |-> !advance;
	endproperty
	a_run_need: assert property (p_run_need) else $error("step without run bit");
	// Shadow follows the latch one clock later unless software writes it
	property p_shadow_follow;
		@(posedge clk) disable iff (sys_rst)
			!ctrl_wr |=> shadow_latch_out == $past(toggle_latch_out);
	endproperty
	a_shadow_follow: assert property (p_shadow_follow) else $error("shadow did not follow latch");
	// Software write loads latch and shadow from the written bit
	property p_sw_latch;
		@(posedge clk) disable iff (sys_rst)
			s_ctrl_write |=> toggle_latch_out == $past(hwdata[ctrd_pkg::BIT_OTL]) &&
				shadow_latch_out == toggle_latch_out;
	endproperty
	a_sw_latch: assert property (p_sw_latch) else $error("latch write wrong");
	// Latch holds without a step or a write
	property p_latch_hold;
		@(posedge clk) disable iff (sys_rst)
			!st_ff.wr_pend && !advance |=> $stable(toggle_latch_out);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved without cause");
	// Wrap pulses always leave their sticky flag set
	property p_ovf_flag;
		@(posedge clk) disable iff (sys_rst)
			st_ff.ovf_pulse |-> st_ff.irq_status[ctrd_pkg::IRQ_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag lost");
	property p_unf_flag;
		@(posedge clk) disable iff (sys_rst)
			st_ff.unf_pulse |-> st_ff.irq_status[ctrd_pkg::IRQ_UNF];
	endproperty
	a_unf_flag: assert property (p_unf_flag) else $error("underflow flag lost");
	// Remote-run bits pass the core run bit to the aux timers
	property p_aux_a;
		@(posedge clk) disable iff (sys_rst)
			st_ff.ctrl[ctrd_pkg::BIT_RUN] && st_ff.aux_cfg[ctrd_pkg::BIT_A_RC] |-> aux_a_run;
	endproperty
	a_aux_a: assert property (p_aux_a) else $error("aux a not started");
	property p_aux_b;
		@(posedge clk) disable iff (sys_rst)
			st_ff.ctrl[ctrd_pkg::BIT_RUN] && st_ff.aux_cfg[ctrd_pkg::BIT_B_RC] |-> aux_b_run;
	endproperty
	a_aux_b: assert property (p_aux_b) else $error("aux b not started");
	// Counter mode with no edge selected never counts
	property p_param_none;
		@(posedge clk) disable iff (sys_rst)
			mode == ctrd_pkg::MODE_COUNTER && param == 3'h0 |-> !advance;
	endproperty
	a_param_none: assert property (p_param_none) else $error("counter counted with no edge");
	// Pin level is ignored while external direction is off
	property p_ext_off;
		@(posedge clk) disable iff (sys_rst)
			!st_ff.ctrl[ctrd_pkg::BIT_UDE] |=> st_ff.ctrl[ctrd_pkg::BIT_RDIR] == $past(st_ff.ctrl[ctrd_pkg::BIT_UD]);
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("pin moved direction while off");
endmodule : ctrd_core

// file: bench/ctrd_pins.sv
// Far-side pin model: external direction, gate and count pins.
// Assumes the bench asks for pin levels; pins move just after a rising edge.
module ctrd_pins (
	input wire logic clk,
	input wire logic dir_req,
	input wire logic gate_req,
	input wire logic cnt_req,
	input wire logic toggle_output_pin,
	output logic ext_dir_input,
	output logic gate_input,
	output logic count_input
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins follow the requests one edge later, settled well before reset ends
	always @(posedge clk) begin
		ext_dir_input <= dir_req;
		gate_input <= gate_req;
		count_input <= cnt_req;
	end
endmodule : ctrd_pins

// file: bench/test_core_timer_run_dir_toggle.sv
// Bench for the core timer control block over AHB-Lite.
// Assumes a zero-wait slave, one 40 MHz clock and the pin model beside it.
module test_core_timer_run_dir_toggle;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic count_tick = 1'b0;
	logic dir_req = 1'b0;
	logic gate_req = 1'b0;
	logic cnt_req = 1'b0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, ext_dir_input, gate_input, count_input, pin, lat, shd, trg, a_run, b_run, irq;
	int n_fail = 0;
	int cmp_count = 0;
	int n_trig = 0;
	// Clock and trigger pulse counter
	always #12.5 clk = ~clk;
	always @(posedge clk) if (trg === 1'b1) n_trig++;
	ctrd_core u_ctrd_core (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick), .gate_input(gate_input),
		.count_input(count_input), .ext_dir_input(ext_dir_input), .toggle_output_pin(pin),
		.toggle_latch_out(lat), .shadow_latch_out(shd), .aux_trigger(trg), .aux_a_run(a_run),
		.aux_b_run(b_run), .irq(irq));
	ctrd_pins u_ctrd_pins (.clk(clk), .dir_req(dir_req), .gate_req(gate_req), .cnt_req(cnt_req),
		.toggle_output_pin(pin),
		.ext_dir_input(ext_dir_input), .gate_input(gate_input), .count_input(count_input));
	// One AHB-Lite single word transfer; read data taken at the data phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdc
	// Counts four count-pin transitions from zero in one counter or incremental setting
	task automatic cnt_run(input string nm, input logic [31:0] c, input logic [31:0] e);
		xfer(1'b1, ctrd_pkg::OFS_COUNT, 32'h0);
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, c);
		repeat (4) begin
			cnt_req <= ~cnt_req;
			repeat (3) @(posedge clk);
		end
		repeat (3) @(posedge clk);
		rdc(nm, ctrd_pkg::OFS_COUNT, e);
	endtask : cnt_run
	// Waits on falling edges, bounded, for the latch to reach a level
	task automatic wait_lat(input logic v);
		for (int i = 0; i < 40 && lat !== v; i++) @(negedge clk);
		chk("latch", {31'h0, v}, {31'h0, lat});
		chk("trig_shadow", {30'h0, 1'b1, ~v}, {30'h0, trg, shd});
		@(negedge clk);
		chk("shadow_pin", {30'h0, v, v}, {30'h0, shd, pin});
	endtask : wait_lat
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog far beyond the expected run length
	initial begin
		#1000000;
		n_fail++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("pin_reset", 32'h1, {31'h0, pin});
		rdc("ctrl_reset", ctrd_pkg::OFS_CONTROL, 32'h0);
		for (int k = 0; k < 8; k++) begin
			dir_req <= k[2];
			xfer(1'b1, ctrd_pkg::OFS_CONTROL, {23'h0, k[1], k[0], 7'h0});
			repeat (2) @(posedge clk);
			rdc("dir", ctrd_pkg::OFS_CONTROL, {16'h0, k[1] ? k[2] ^ k[0] : k[0], 6'h0, k[1], k[0], 7'h0});
		end
		for (int m = 0; m < 8; m++) if (m != 4 && m != 5) begin
			xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'(m * 9));
			rdc("mode_param", ctrd_pkg::OFS_CONTROL, 32'(m * 9));
		end
		xfer(1'b1, ctrd_pkg::OFS_IRQ_MASK, 32'h3);
		xfer(1'b1, ctrd_pkg::OFS_COUNT, 32'hFFFF);
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0240);
		n_trig = 0;
		count_tick <= 1'b1;
		wait_lat(1'b1);
		chk("ovf_irq", 32'h1, {31'h0, irq});
		rdc("ovf_status", ctrd_pkg::OFS_IRQ_STATUS, 32'h1);
		xfer(1'b1, ctrd_pkg::OFS_IRQ_STATUS, 32'h1);
		@(negedge clk);
		chk("irq_clear", 32'h0, {31'h0, irq});
		count_tick <= 1'b0;
		xfer(1'b1, ctrd_pkg::OFS_COUNT, 32'h0);
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h06C0);
		count_tick <= 1'b1;
		wait_lat(1'b0);
		rdc("unf_status", ctrd_pkg::OFS_IRQ_STATUS, 32'h2);
		chk("trig_count", 32'h2, 32'(n_trig));
		xfer(1'b1, ctrd_pkg::OFS_IRQ_STATUS, 32'h2);
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0400);
		@(negedge clk);
		chk("sw_latch", 32'h3, {30'h0, lat, shd});
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0000);
		@(negedge clk);
		chk("sw_clear_pin", 32'h1, {29'h0, lat, shd, pin});
		chk("no_trig", 32'h2, 32'(n_trig));
		xfer(1'b1, ctrd_pkg::OFS_COUNT, 32'h1234);
		repeat (4) @(posedge clk);
		rdc("stopped", ctrd_pkg::OFS_COUNT, 32'h1234);
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0058);
		repeat (4) @(posedge clk);
		rdc("gate_off", ctrd_pkg::OFS_COUNT, 32'h1234);
		gate_req <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(1'b0, ctrd_pkg::OFS_COUNT, 32'h0);
		chk("gate_on", 32'h1, {31'h0, rd !== 32'h1234});
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0050);
		xfer(1'b1, ctrd_pkg::OFS_COUNT, 32'h1234);
		repeat (4) @(posedge clk);
		rdc("gate_lo_off", ctrd_pkg::OFS_COUNT, 32'h1234);
		gate_req <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(1'b0, ctrd_pkg::OFS_COUNT, 32'h0);
		chk("gate_lo_on", 32'h1, {31'h0, rd !== 32'h1234});
		xfer(1'b1, ctrd_pkg::OFS_AUX_CFG, 32'h1);
		@(negedge clk);
		chk("aux_a", 32'h2, {30'h0, a_run, b_run});
		xfer(1'b1, ctrd_pkg::OFS_AUX_CFG, 32'h2);
		@(negedge clk);
		chk("aux_b", 32'h1, {30'h0, a_run, b_run});
		xfer(1'b1, ctrd_pkg::OFS_CONTROL, 32'h0);
		@(negedge clk);
		chk("aux_stop", 32'h0, {30'h0, a_run, b_run});
		cnt_run("cnt_none", 32'h0048, 32'h0);
		cnt_run("cnt_rise", 32'h0049, 32'h2);
		cnt_run("cnt_fall", 32'h004A, 32'h2);
		cnt_run("cnt_any", 32'h004B, 32'h4);
		cnt_run("inc_rot", 32'h0071, 32'h4);
		cnt_run("inc_edge", 32'h007B, 32'h4);
		rdc("unmapped", 8'h20, 32'h0);
		tally_and_finish();
	end
endmodule : test_core_timer_run_dir_toggle
